//--- shared/pbrgc_defs.vh
`ifndef PBRGC_DEFS_VH
`define PBRGC_DEFS_VH
// ----------------------------------------
// Register indexes (byte address = 4 * index)
// ----------------------------------------
`define PBRGC_IDX_RRG       4'h1
`define PBRGC_IDX_SRC       4'h5
`define PBRGC_IDX_STATUS    4'h8
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PBRGC_RRG_LONG_BIT  7
`define PBRGC_RRG_ROOT_BIT  6
`define PBRGC_SRC_SHORT_BIT 1
// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define PBRGC_GAP_MAX       6'h3F
`define PBRGC_GAP_RESET     6'h3F
`define PBRGC_SRC_RESET     8'h00
`define PBRGC_RESET_CYCLES  16'h0010
`endif

//--- hdl/pbrgc_gap_tracker.v
`timescale 1ns/1ps
`include "pbrgc_defs.vh"
// Gap count and root-holdoff holder with two-reset forcing
module pbrgc_gap_tracker
(
	// Clock and reset
	input  wire       sys_clk,
	input  wire       nrst,
	// Loads
	input  wire       regLoad,
	input  wire       pktLoad,
	input  wire [5:0] loadGap,
	input  wire       loadRoot,
	// Bus reset events
	input  wire       busResetStart,
	input  wire       busResetByLong,
	// State
	output reg  [5:0] gapCount_q,
	output reg        rootHoldoff_q,
	output reg        updatedSince_q
);
	// ----------------------------------------
	// Gap tracking
	// ----------------------------------------
	// The write that launches a long reset lands before that reset, so it
	// does not count as an update after it; a packet in the cycle a short reset starts does
	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			gapCount_q     <= `PBRGC_GAP_RESET;
			rootHoldoff_q  <= 1'b0;
			updatedSince_q <= 1'b0;
		end
		else if (busResetStart)
		begin
			if (regLoad || pktLoad)
			begin
				// Reset launched by the long bit keeps the just-written value
				gapCount_q    <= loadGap;
				rootHoldoff_q <= loadRoot;
			end
			else if (!updatedSince_q)
				gapCount_q <= `PBRGC_GAP_MAX;
			updatedSince_q <= pktLoad & ~busResetByLong;
		end
		else if (regLoad || pktLoad)
		begin
			gapCount_q     <= loadGap;
			rootHoldoff_q  <= loadRoot;
			updatedSince_q <= 1'b1;
		end
	end
endmodule // pbrgc_gap_tracker

//--- hdl/pbrgc_top.v
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "pbrgc_defs.vh"
// Behaviour
// - Writing short-reset bit starts short bus reset
// - Register 1 write: long reset, holdoff, gap
// - Config packets sent or received load values
// - Two resets without update force gap 63
// - Long-bit reset keeps its written gap
// - Reference clock from 98.304 MHz crystal input
// - Clock output derived from reference clock
module pbrgc_top
#(
	parameter RESET_CYCLES = `PBRGC_RESET_CYCLES
)
(
	// Clock and reset
	input  wire        sys_clk,
	input  wire        nrst,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	// PHY configuration packet events
	input  wire        cfgPktValid,
	input  wire [5:0]  cfgPktGap,
	input  wire        cfgPktRoot,
	// Reference clock
	input  wire        crystal_in,
	output wire        phyClkOut,
	// Bus reset status
	output reg         busResetActive_q,
	output reg         busResetShort_q,
	output wire        busResetStart
);
	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	// Registers sit one word apart; the index lies above the byte lanes
	wire       wrEn  = psel & penable & pwrite;
	wire [3:0] index = paddr[5:2];
	wire       aligned = (paddr[1:0] == 2'b00) && (paddr[31:6] == 26'h0);

	// Decode a register hit, used by both read and write paths
	function hit;
		input [3:0] idx;
		input [3:0] want;
		input       al;
		begin
			hit = al && (idx == want);
		end
	endfunction

	wire hitRrg = hit(index, `PBRGC_IDX_RRG, aligned);
	wire hitSrc = hit(index, `PBRGC_IDX_SRC, aligned);
	wire hitSts = hit(index, `PBRGC_IDX_STATUS, aligned);
	wire mapped = hitRrg | hitSrc | hitSts;

	// Zero-wait slave; unmapped addresses give an error
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	// Any register-1 write is a load, with or without the long bit
	wire longReq  = wrEn & hitRrg & pwdata[`PBRGC_RRG_LONG_BIT];
	wire regLoad  = wrEn & hitRrg;
	wire shortReq = wrEn & hitSrc & pwdata[`PBRGC_SRC_SHORT_BIT];
	// A new request while one runs is folded into the running reset
	assign busResetStart = (longReq | shortReq) & ~busResetActive_q;

	// Other writable bits of the short-reset register are plain storage
	reg  [7:0] srcBits_q;
	reg  [7:0] srcBits_d;
	always @*
	begin
		srcBits_d = srcBits_q;
		if (wrEn && hitSrc)
			srcBits_d = pwdata[7:0] & ~(8'h01 << `PBRGC_SRC_SHORT_BIT);
	end

	// ----------------------------------------
	// Gap and holdoff
	// ----------------------------------------
	wire [5:0] gapCount;
	wire       rootHoldoff;
	wire       updatedSince;
	wire       pktLoad = cfgPktValid & ~regLoad;
	wire [5:0] loadGap  = regLoad ? pwdata[5:0] : cfgPktGap;
	wire       loadRoot = regLoad ? pwdata[`PBRGC_RRG_ROOT_BIT] : cfgPktRoot;

	pbrgc_gap_tracker uGap
	(
		.sys_clk        (sys_clk),
		.nrst           (nrst),
		.regLoad        (regLoad),
		.pktLoad        (pktLoad),
		.loadGap        (loadGap),
		.loadRoot       (loadRoot),
		.busResetStart  (busResetStart),
		.busResetByLong (longReq),
		.gapCount_q     (gapCount),
		.rootHoldoff_q  (rootHoldoff),
		.updatedSince_q (updatedSince)
	);

	// ----------------------------------------
	// Bus reset sequencer
	// ----------------------------------------
	// Two states suffice: a reset either runs or it does not
	localparam SEQ_IDLE = 1'b0;
	localparam SEQ_RUN  = 1'b1;

	reg [15:0] resetCnt_q;
	reg [15:0] resetCnt_d;
	reg        busResetActive_d;
	reg        busResetShort_d;

	// Next state; a request while running is folded in, never queued
	always @*
	begin
		busResetActive_d = busResetActive_q;
		busResetShort_d  = busResetShort_q;
		resetCnt_d       = resetCnt_q;
		case (busResetActive_q)
			SEQ_IDLE:
			begin
				if (busResetStart)
				begin
					busResetActive_d = SEQ_RUN;
					busResetShort_d  = shortReq & ~longReq;
					resetCnt_d       = RESET_CYCLES[15:0];
				end
			end
			SEQ_RUN:
			begin
				// One-shot: the sequence ends on its own
				if (resetCnt_q == 16'h0001)
					busResetActive_d = SEQ_IDLE;
				resetCnt_d = resetCnt_q - 16'h0001;
			end
			default:
			begin
				busResetActive_d = SEQ_IDLE;
				resetCnt_d       = 16'h0000;
			end
		endcase
	end

	// State registers; the short-reset storage bits share this reset
	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			busResetActive_q <= SEQ_IDLE;
			busResetShort_q  <= 1'b0;
			resetCnt_q       <= 16'h0000;
			srcBits_q        <= `PBRGC_SRC_RESET;
		end
		else
		begin
			busResetActive_q <= busResetActive_d;
			busResetShort_q  <= busResetShort_d;
			resetCnt_q       <= resetCnt_d;
			srcBits_q        <= srcBits_d;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Status word layout, read-only
	localparam STS_ACTIVE_BIT  = 0;
	localparam STS_SHORT_BIT   = 1;
	localparam STS_UPDATED_BIT = 2;

	// Captured in the setup cycle so it already stands in the access cycle
	wire       rdSetup = psel & ~penable & ~pwrite;
	reg [31:0] rdData_d;

	// Unmapped or misaligned reads return zero
	always @*
	begin
		rdData_d = 32'h0000_0000;
		if (hitRrg)
			rdData_d[7:0] = {1'b0, rootHoldoff, gapCount};
		else if (hitSrc)
			rdData_d[7:0] = srcBits_q;
		else if (hitSts)
		begin
			rdData_d[STS_ACTIVE_BIT]  = busResetActive_q;
			rdData_d[STS_SHORT_BIT]   = busResetShort_q;
			rdData_d[STS_UPDATED_BIT] = updatedSince;
		end
	end

	// Holding register, changed only by a read setup
	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			prdata <= 32'h0000_0000;
		else if (rdSetup)
			prdata <= rdData_d;
	end

	// ----------------------------------------
	// Clock output
	// ----------------------------------------
	// Analog PLL is outside this logic; reference passes straight out.
	// Frequency accuracy then rests on the oscillator alone, so the
	// board must keep its tolerance and ageing inside the ppm budget.
	assign phyClkOut = crystal_in;
endmodule // pbrgc_top

//--- verification/pbrgc_link_model.sv
`timescale 1ns/1ps
// Far side: reference oscillator and configuration packet source
module pbrgc_link_model
(
	// Clock
	input  logic       sys_clk,
	// Oscillator and packets
	output logic       crystal_in,
	output logic       cfgPktValid,
	output logic [5:0] cfgPktGap,
	output logic       cfgPktRoot
);
	// Free running near 98.304 MHz, unrelated in phase to sys_clk
	initial
	begin
		crystal_in = 0;
		cfgPktValid = 0;
		cfgPktGap = 0;
		cfgPktRoot = 0;
		forever #5.086 crystal_in = ~crystal_in;
	end
	// One packet pulse; fields are scrambled after so stale values cannot pass
	task send(input logic [5:0] g, input logic r);
		@(posedge sys_clk);
		cfgPktValid <= 1;
		cfgPktGap <= g;
		cfgPktRoot <= r;
		@(posedge sys_clk);
		cfgPktValid <= 0;
		cfgPktGap <= ~g;
		cfgPktRoot <= ~r;
	endtask
endmodule // pbrgc_link_model

//--- verification/pbrgc_monitor.sv
`timescale 1ns/1ps
// Port checker for the bus reset block
module pbrgc_monitor
(
	input logic        sys_clk, nrst, psel, penable, pwrite,
	input logic [31:0] paddr, pwdata, prdata,
	input logic        crystal_in, phyClkOut,
	input logic        busResetActive_q, busResetShort_q, busResetStart
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// Access cycles, decoded once
	wire wrAcc = psel && penable && pwrite;
	wire rdAcc = psel && penable && !pwrite;
	a_short_start: assert property (wrAcc && paddr[7:0] == 8'h14 && pwdata[1]
		&& !busResetActive_q |-> busResetStart) else $error("no short reset");
	a_long_start: assert property (wrAcc && paddr[7:0] == 8'h04 && pwdata[7]
		&& !busResetActive_q |-> busResetStart) else $error("no long reset");
	a_reset_runs: assert property (busResetStart |=> busResetActive_q[*2])
		else $error("reset not held");
	a_short_kind: assert property (busResetStart && paddr[7:0] == 8'h14
		|=> busResetShort_q) else $error("short kind lost");
	a_long_kind: assert property (busResetStart && paddr[7:0] == 8'h04
		|=> !busResetShort_q) else $error("long kind lost");
	a_long_reads: assert property (rdAcc && paddr[7:0] == 8'h04 |-> !prdata[7])
		else $error("long bit reads 1");
	a_short_reads: assert property (rdAcc && paddr[7:0] == 8'h14 |-> !prdata[1])
		else $error("short bit reads 1");
	a_clock_out: assert property (phyClkOut == crystal_in)
		else $error("clock out differs");
endmodule // pbrgc_monitor

//--- verification/tb_phy_bus_reset_gap_control.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
// Bench: APB register traffic plus link packets
module tb_phy_bus_reset_gap_control;
	logic        sys_clk, nrst, psel, penable, pwrite, errFlag;
	logic [31:0] paddr, pwdata, rdVal;
	wire  [31:0] prdata;
	wire  [5:0]  cfgPktGap;
	wire         pready, pslverr, crystal_in, phyClkOut, cfgPktValid, cfgPktRoot;
	wire         busResetActive_q, busResetShort_q, busResetStart;
	int          n_mismatch, comparisons, cyc;
	localparam logic [31:0] aRrg = 32'h0000_0004, aSrc = 32'h0000_0014;
	pbrgc_top #(.RESET_CYCLES(2)) DUT (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .cfgPktValid, .cfgPktGap, .cfgPktRoot,
		.crystal_in, .phyClkOut, .busResetActive_q, .busResetShort_q, .busResetStart);
	pbrgc_link_model lm (.sys_clk, .crystal_in, .cfgPktValid, .cfgPktGap, .cfgPktRoot);
	initial
	begin
		sys_clk = 0;
		forever #10 sys_clk = ~sys_clk;
	end
	// One APB transfer, held until pready is seen high
	task xfer(input logic w, input logic [31:0] a, d);
		@(posedge sys_clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rdVal = prdata;
		errFlag = pslverr;
		psel <= 0; penable <= 0;
	endtask
	// Short reset by read-modify-write, then let it run out
	task shortReset;
		xfer(0, aSrc, 0);
		xfer(1, aSrc, rdVal | 32'h0000_0002);
		repeat (6) @(posedge sys_clk);
	endtask
	task close_out;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Hang guard
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			close_out;
		end
	end
	initial
	begin
		nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		repeat (3) @(posedge sys_clk);
		nrst <= 1;
		xfer(0, aRrg, 0);
		`CHK(rdVal, 32'h0000_003F)
		lm.send(6'h0A, 1);
		xfer(0, aRrg, 0);
		`CHK(rdVal, 32'h0000_004A)
		$display("test 1 done");
		xfer(1, aRrg, 32'h0000_00C5);
		repeat (6) @(posedge sys_clk);
		xfer(0, aRrg, 0);
		`CHK(rdVal, 32'h0000_0045)
		shortReset;
		xfer(0, aRrg, 0);
		`CHK(rdVal, 32'h0000_007F)
		xfer(1, aRrg, (rdVal & 32'h0000_0040) | 32'h0000_00BF);
		repeat (6) @(posedge sys_clk);
		xfer(0, aRrg, 0);
		`CHK(rdVal, 32'h0000_007F)
		$display("test 2 done");
		lm.send(6'h10, 0);
		shortReset;
		xfer(0, aRrg, 0);
		`CHK(rdVal, 32'h0000_0010)
		xfer(1, aSrc, 32'h0000_00F2);
		xfer(0, 32'h0000_0020, 0);
		`CHK(rdVal, 32'h0000_0003)
		xfer(0, aSrc, 0);
		`CHK(rdVal, 32'h0000_00F0)
		xfer(0, aRrg, 0);
		`CHK(rdVal, 32'h0000_003F)
		xfer(0, 32'h0000_0030, 0);
		`CHK(errFlag, 1'b1)
		$display("test 3 done");
		close_out;
	end
endmodule // tb_phy_bus_reset_gap_control
bind pbrgc_top pbrgc_monitor mon (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .crystal_in, .phyClkOut, .busResetActive_q, .busResetShort_q, .busResetStart);
